// ===== rtl/i2csf_pkg.sv
// package for the two-wire bus status flag block
// assumes one peripheral clock and a 32-bit apb register bus
package i2csf_pkg;
   // register byte offsets (word aligned)
   localparam logic [7:0] STAT_OFF = 8'h00; // serial_bus_status
   localparam logic [7:0] TXH_OFF = 8'h04; // transmit_holding_register
   localparam logic [7:0] RXH_OFF = 8'h08; // receive_holding_register
   // status bit positions
   localparam int ACK_BIT = 15;
   localparam int TXP_BIT = 14;
   localparam int COL_BIT = 10;
   localparam int GC_BIT = 9;
   localparam int TEN_BIT = 8;
   localparam int WCOL_BIT = 7;
   localparam int OV_BIT = 6;
   localparam int DA_BIT = 5;
   localparam int STOP_BIT = 4;
   localparam int START_BIT = 3;
   localparam int RW_BIT = 2;
   localparam int RXF_BIT = 1;
   localparam int TXF_BIT = 0;
   // flags that software may clear by writing zero
   localparam logic [31:0] SW_CLR_MASK = 32'h0000_04D8;
   localparam logic [31:0] STAT_RESET = 32'h0000_0000;
   // events reported by the bus engine, one-cycle pulses except the busy level
   typedef struct packed {
      logic tx_start;   // master transmission begins
      logic ack_slot;   // end of slave acknowledge slot
      logic ack_nack;   // sampled ack bit, 1 = nack
      logic collision;  // bus collision in master op
      logic gen_call;   // address equals general call
      logic ten_match;  // second ten-bit byte matched
      logic addr_match; // device address matched
      logic addr_read;  // r/w bit of that address
      logic data_rx;    // data byte received as slave
      logic start_cond; // start or repeated start
      logic stop_cond;  // stop detected
      logic byte_rx;    // byte ready in shift register
      logic tx_done;    // transmit data fully sent
      logic busy;       // engine busy (level)
   } i2csf_evt_t;
endpackage

// ===== rtl/i2csf_status.sv
// status flags of a two-wire bus controller with an apb register port
// assumes bus-engine events are synchronous to clk_i, single-cycle pulses except the busy level
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module i2csf_status (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire i2csf_pkg::i2csf_evt_t evt_i,
   input wire logic [7:0] rx_shift_i,
   output logic [7:0] tx_data_o,
   output logic tx_load_o
);
   import i2csf_pkg::*;

   // flag registers
   logic ack_result_flag_q;
   logic tx_progress_flag_q;
   logic collision_flag_q;
   logic general_call_flag_q;
   logic ten_bit_match_flag_q;
   logic write_collision_flag_q;
   logic rx_overflow_flag_q;
   logic data_flag_q;
   logic stop_flag_q;
   logic start_flag_q;
   logic read_dir_flag_q;
   logic rx_full_flag_q;
   logic tx_full_flag_q;
   logic [7:0] rx_hold_q; // receive_holding_register
   logic [7:0] tx_hold_q; // transmit_holding_register
   logic tx_load_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   // apb decode: access phase, answered in one wait cycle
   wire acc = psel_i & penable_i & ~pready_q;
   wire hit_stat = (paddr_i == STAT_OFF);
   wire hit_txh = (paddr_i == TXH_OFF);
   wire hit_rxh = (paddr_i == RXH_OFF);
   wire mapped = hit_stat | hit_txh | hit_rxh;
   wire wr_stat = acc & pwrite_i & hit_stat;
   wire wr_txh = acc & pwrite_i & hit_txh;
   wire rd_rxh = acc & ~pwrite_i & hit_rxh;
   // transmit write refused while engine busy or buffer still full
   wire tx_reject = wr_txh & (evt_i.busy | tx_full_flag_q);
   wire tx_accept = wr_txh & ~tx_reject;
   // zero written to a clearable bit clears it
   wire [31:0] sw_clr = (wr_stat ? ~pwdata_i : 32'h0000_0000) & SW_CLR_MASK;
   // receive transfer finds holding register still full
   wire ovf_evt = evt_i.byte_rx & rx_full_flag_q & ~rd_rxh;

   // assembled status word, unimplemented bits tied low
   wire [31:0] status_word = {16'h0000, ack_result_flag_q, tx_progress_flag_q,
      3'b000, collision_flag_q, general_call_flag_q, ten_bit_match_flag_q,
      write_collision_flag_q, rx_overflow_flag_q, data_flag_q, stop_flag_q,
      start_flag_q, read_dir_flag_q, rx_full_flag_q, tx_full_flag_q};
   wire [31:0] rd_mux = hit_stat ? status_word :
      hit_rxh ? {24'h0000_00, rx_hold_q} :
      hit_txh ? {24'h0000_00, tx_hold_q} : 32'h0000_0000;

   // apb answer registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= acc;
         pslverr_q <= acc & ~mapped;
         prdata_q <= (acc & ~pwrite_i) ? rd_mux : 32'h0000_0000;
      end
   end

   // master transmit flags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_result_flag_q <= 1'b0;
         tx_progress_flag_q <= 1'b0;
      end else begin
         if (evt_i.ack_slot) begin
            ack_result_flag_q <= evt_i.ack_nack;
         end
         // start wins if a new byte begins as the ack ends
         if (evt_i.tx_start) begin
            tx_progress_flag_q <= 1'b1;
         end else if (evt_i.ack_slot) begin
            tx_progress_flag_q <= 1'b0;
         end
      end
   end

   // sticky error flags: hardware set beats software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         collision_flag_q <= 1'b0;
         write_collision_flag_q <= 1'b0;
         rx_overflow_flag_q <= 1'b0;
      end else begin
         collision_flag_q <= evt_i.collision | (collision_flag_q & ~sw_clr[COL_BIT]);
         write_collision_flag_q <= tx_reject |
            (write_collision_flag_q & ~sw_clr[WCOL_BIT]);
         rx_overflow_flag_q <= ovf_evt | (rx_overflow_flag_q & ~sw_clr[OV_BIT]);
      end
   end

   // address match flags, dropped at stop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         general_call_flag_q <= 1'b0;
         ten_bit_match_flag_q <= 1'b0;
      end else begin
         if (evt_i.gen_call) begin
            general_call_flag_q <= 1'b1;
         end else if (evt_i.stop_cond) begin
            general_call_flag_q <= 1'b0;
         end
         if (evt_i.ten_match) begin
            ten_bit_match_flag_q <= 1'b1;
         end else if (evt_i.stop_cond) begin
            ten_bit_match_flag_q <= 1'b0;
         end
      end
   end

   // slave byte type and direction
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_flag_q <= 1'b0;
         read_dir_flag_q <= 1'b0;
      end else begin
         if (evt_i.addr_match) begin
            data_flag_q <= 1'b0;
            read_dir_flag_q <= evt_i.addr_read;
         end else if (evt_i.data_rx) begin
            data_flag_q <= 1'b1;
         end
      end
   end

   // start/stop: last condition wins; a hardware event beats a software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_flag_q <= 1'b0;
         start_flag_q <= 1'b0;
      end else if (evt_i.start_cond) begin
         start_flag_q <= 1'b1;
         stop_flag_q <= 1'b0;
      end else if (evt_i.stop_cond) begin
         stop_flag_q <= 1'b1;
         start_flag_q <= 1'b0;
      end else begin
         stop_flag_q <= stop_flag_q & ~sw_clr[STOP_BIT];
         start_flag_q <= start_flag_q & ~sw_clr[START_BIT];
      end
   end

   // receive holding register; an overflowing byte is dropped, old one kept
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_hold_q <= 8'h00;
         rx_full_flag_q <= 1'b0;
      end else if (evt_i.byte_rx & ~ovf_evt) begin
         rx_hold_q <= rx_shift_i;
         rx_full_flag_q <= 1'b1;
      end else if (rd_rxh) begin
         rx_full_flag_q <= 1'b0;
      end
   end

   // transmit holding register and load pulse to the engine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_hold_q <= 8'h00;
         tx_full_flag_q <= 1'b0;
         tx_load_q <= 1'b0;
      end else begin
         tx_load_q <= tx_accept;
         if (tx_accept) begin
            tx_hold_q <= pwdata_i[7:0];
            tx_full_flag_q <= 1'b1;
         end else if (evt_i.tx_done) begin
            tx_full_flag_q <= 1'b0;
         end
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign tx_data_o = tx_hold_q;
   assign tx_load_o = tx_load_q;

   AST_ACK_FOLLOWS: assert property (@(posedge clk_i) disable iff (rst_i)
      evt_i.ack_slot |=> ack_result_flag_q == $past(evt_i.ack_nack))
      else $error("ack flag not updated");
   AST_TXP_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
      evt_i.ack_slot && !evt_i.tx_start |=> !tx_progress_flag_q)
      else $error("tx progress not dropped");
   AST_COL_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
      collision_flag_q && !sw_clr[COL_BIT] |=> collision_flag_q)
      else $error("collision flag lost");
   AST_GC_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
      evt_i.stop_cond && !evt_i.gen_call |=> !general_call_flag_q)
      else $error("general call not cleared");
   AST_TEN_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      evt_i.ten_match |=> ten_bit_match_flag_q)
      else $error("ten-bit flag not set");
   AST_WCOL: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_txh && evt_i.busy |=> write_collision_flag_q && !tx_load_o)
      else $error("busy write not rejected");
   AST_OVF: assert property (@(posedge clk_i) disable iff (rst_i)
      ovf_evt |=> rx_overflow_flag_q && rx_full_flag_q)
      else $error("overflow not flagged");
   AST_DA: assert property (@(posedge clk_i) disable iff (rst_i)
      evt_i.addr_match |=> !data_flag_q)
      else $error("data flag not cleared on address");
   AST_SS_EXCL: assert property (@(posedge clk_i) disable iff (rst_i)
      !(stop_flag_q && start_flag_q))
      else $error("start and stop both set");
   AST_START: assert property (@(posedge clk_i) disable iff (rst_i)
      evt_i.start_cond |=> start_flag_q && !stop_flag_q)
      else $error("start flag wrong");
   AST_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
      evt_i.addr_match |=> read_dir_flag_q == $past(evt_i.addr_read))
      else $error("direction flag wrong");
   AST_RXF_RD: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_rxh && !evt_i.byte_rx |=> !rx_full_flag_q)
      else $error("rx full not cleared");
   AST_TXF: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_accept |=> tx_full_flag_q ##0 tx_load_o)
      else $error("tx full not set");
   AST_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      pready_q |-> prdata_q[31:16] == 16'h0000)
      else $error("upper bits nonzero");

   // set or clear of a flag: visible one cycle after its event
   AST_TXP_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      evt_i.tx_start |=> tx_progress_flag_q)
      else $error("tx progress not set");
   AST_COL_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      evt_i.collision |=> collision_flag_q)
      else $error("collision flag not set");
   AST_GC_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      evt_i.gen_call |=> general_call_flag_q)
      else $error("general call flag not set");
   AST_TEN_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
      evt_i.stop_cond && !evt_i.ten_match |=> !ten_bit_match_flag_q)
      else $error("ten-bit flag not cleared");
   AST_DA_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      evt_i.data_rx && !evt_i.addr_match |=> data_flag_q)
      else $error("data flag not set");
   AST_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
      evt_i.stop_cond && !evt_i.start_cond |=> stop_flag_q && !start_flag_q)
      else $error("stop flag wrong");
   AST_RXF_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      evt_i.byte_rx && !rx_full_flag_q |=> rx_full_flag_q && rx_hold_q == $past(rx_shift_i))
      else $error("receive byte not loaded");
   AST_TXF_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
      evt_i.tx_done && !tx_accept |=> !tx_full_flag_q)
      else $error("tx full not cleared");

   // hold side: flags and the held byte move only on their own events or a software clear
   AST_ACK_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      !evt_i.ack_slot |=> $stable(ack_result_flag_q))
      else $error("ack flag moved without ack slot");
   AST_WCOL_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
      write_collision_flag_q && !sw_clr[WCOL_BIT] |=> write_collision_flag_q)
      else $error("write collision flag lost");
   AST_OVF_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
      ovf_evt |=> rx_hold_q == $past(rx_hold_q))
      else $error("overflowing byte overwrote held byte");
   AST_DIR_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      !evt_i.addr_match |=> $stable(read_dir_flag_q))
      else $error("direction flag moved without address");
   // a zero written to the start bit clears it when no condition competes
   AST_SW_CLR_START: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_stat && !pwdata_i[START_BIT] && !evt_i.start_cond && !evt_i.stop_cond
      |=> !start_flag_q)
      else $error("start flag not cleared by software");
endmodule

// ===== sim/i2csf_bus_model.sv
// bus engine model: the far side of the status block
// assumes the bench calls pulse() for bus and slave events
`timescale 1ns/1ps
module i2csf_bus_model (
   input wire logic clk_i,
   input wire logic tx_load_i, // byte handed over to send
   input wire logic nack_i, // slave answer for that byte
   output i2csf_pkg::i2csf_evt_t evt_o,
   output logic [7:0] rx_shift_o
);
   import i2csf_pkg::*;
   i2csf_evt_t ext_q = '0; // events pulsed by the bench
   i2csf_evt_t eng_q = '0; // events of the byte engine
   int cnt_q = 0; // bit times left
   initial rx_shift_o = 8'h00;
   assign evt_o = ext_q | eng_q;
   // eight data bits plus ack, busy until the ack slot
   always @(posedge clk_i) begin
      eng_q <= '0;
      if (tx_load_i) begin
         cnt_q <= 9;
         eng_q.tx_start <= 1'b1;
         eng_q.busy <= 1'b1;
      end else if (cnt_q != 0) begin
         cnt_q <= cnt_q - 1;
         eng_q.busy <= (cnt_q != 1);
         eng_q.ack_slot <= (cnt_q == 1);
         eng_q.ack_nack <= (cnt_q == 1) && nack_i;
         eng_q.tx_done <= (cnt_q == 1);
      end
   end
   // one-cycle event; shift data turns stale after it
   task automatic pulse(input i2csf_evt_t e, input logic [7:0] b);
      @(posedge clk_i);
      ext_q <= e;
      rx_shift_o <= b;
      @(posedge clk_i);
      ext_q <= '0;
      rx_shift_o <= ~b;
   endtask
endmodule

// ===== sim/i2c_status_flags_tb.sv
// self-checking bench of the status flag block
// assumes the bus model makes every bus-engine event
`timescale 1ns/1ps
module i2c_status_flags_tb;
   import i2csf_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, tx_load_o;
   logic [7:0] tx_data_o, rx_shift;
   logic nack = 1'b0; // slave answer for the next byte
   i2csf_evt_t evt;
   int n_fail = 0;
   int comparisons = 0;
   i2csf_status i_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .evt_i(evt), .rx_shift_i(rx_shift),
      .tx_data_o(tx_data_o), .tx_load_o(tx_load_o));
   i2csf_bus_model i_bus (.clk_i(clk_i), .tx_load_i(tx_load_o), .nack_i(nack),
      .evt_o(evt), .rx_shift_o(rx_shift));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // setup, then access held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
      output logic [31:0] d, output logic e);
      int k;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= v;
      @(posedge clk_i);
      penable_i <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (pready_o !== 1'b1 && k < 20);
      d = prdata_o;
      e = pslverr_o;
      if (k >= 20) begin
         n_fail++;
         $display("wrong value at %0t: no pready", $time);
         end_sim();
      end
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic e;
      apb(1'b0, a, 32'h0000_0000, d, e);
      chk(d, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] d;
      logic e;
      apb(1'b1, a, v, d, e);
   endtask
   task automatic t_reset();
      logic [31:0] d;
      logic e;
      rd(STAT_OFF, STAT_RESET);
      wr(STAT_OFF, 32'hFFFF_FFFF);
      rd(STAT_OFF, 32'h0000_0000);
      apb(1'b0, 8'h0C, 32'h0000_0000, d, e);
      chk({31'h0000_0000, e}, 32'h0000_0001);
   endtask
   // second write lands while busy and full, so it bounces
   // the ack bit keeps the previous byte's answer until the next slot
   task automatic t_tx(input logic nk, input logic [31:0] mid, input logic [31:0] exp);
      nack <= nk;
      wr(TXH_OFF, 32'h0000_005A);
      wr(TXH_OFF, 32'h0000_00C3);
      chk({24'h00_0000, tx_data_o}, 32'h0000_005A);
      rd(STAT_OFF, mid);
      for (int k = 0; k < 40 && evt.ack_slot !== 1'b1; k++) @(posedge clk_i);
      if (evt.ack_slot !== 1'b1) begin
         n_fail++;
         $display("wrong value at %0t: no acknowledge slot", $time);
         end_sim();
      end
      rd(STAT_OFF, exp);
      wr(STAT_OFF, 32'hFFFF_FF7F);
      rd(STAT_OFF, exp & 32'hFFFF_FF7F);
   endtask
   task automatic t_cond();
      i_bus.pulse('{gen_call:1, ten_match:1, start_cond:1, default:0}, 8'h00);
      rd(STAT_OFF, 32'h0000_0308);
      i_bus.pulse('{collision:1, stop_cond:1, default:0}, 8'h00);
      rd(STAT_OFF, 32'h0000_0410);
      wr(STAT_OFF, 32'h0000_0000);
      rd(STAT_OFF, 32'h0000_0000);
   endtask
   task automatic t_slave();
      i_bus.pulse('{addr_match:1, addr_read:1, default:0}, 8'h00);
      rd(STAT_OFF, 32'h0000_0004);
      i_bus.pulse('{data_rx:1, default:0}, 8'h00);
      rd(STAT_OFF, 32'h0000_0024);
      i_bus.pulse('{addr_match:1, default:0}, 8'h00);
      rd(STAT_OFF, 32'h0000_0000);
   endtask
   // a second byte before the read must not overwrite the first
   task automatic t_rx();
      i_bus.pulse('{byte_rx:1, default:0}, 8'hA5);
      rd(STAT_OFF, 32'h0000_0002);
      i_bus.pulse('{byte_rx:1, default:0}, 8'h3C);
      rd(STAT_OFF, 32'h0000_0042);
      rd(RXH_OFF, 32'h0000_00A5);
      rd(STAT_OFF, 32'h0000_0040);
      wr(STAT_OFF, 32'h0000_0000);
      rd(STAT_OFF, 32'h0000_0000);
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_tx(1'b1, 32'h0000_4081, 32'h0000_8080);
      t_tx(1'b0, 32'h0000_C081, 32'h0000_0080);
      t_cond();
      t_slave();
      t_rx();
      end_sim();
   end
endmodule
